/* File: rtl/keypad_entry_and_row_decoder.v */
// What this block does
// - Each key gives its own five-bit code per the fixed keycode table.
// - VERB blanks the verb field; next two digits become the shown verb.
// - NOUN blanks the noun field; next two digits become the shown noun.
// - Nothing executes until the ENTER keycode arrives.
// - Repeating VERB or NOUN with new digits before ENTER replaces the code.
// - If data is needed, verb and noun flash about once a second after ENTER.
// - Flashing stops when the data is keyed and ENTER pressed.
// - Data is octal unless a sign key starts it; no mixing allowed.
// - Digit 8 or 9 in an octal word raises the computer-fail alarm.
// - Plus or minus shows the sign and makes the word decimal.
// - CLEAR before ENTER discards the data being entered.
// - Error-reset key also pulses a lamp clear signal for alarm flops.
// - Error-reset keycode drops the alarm outputs, putting out computer-fail.
// - Lamp key-release when computer wants the operator-held display; key hands back.
// - Activity lamp lit while the computer is running.
// - Uplink lamp lit only with switch at accept and uplink data present.
// - Bits 15..12 of the output word pick one of thirteen relay rows.
// - Row code 0001 selects relay row 1.
// - Row code goes true and complemented as eight bits; one row matches, none for codes 0000, 1101 and 1111.
// - Thirteen rows of eleven relays; column n follows word bit n.
// - Relays change only at selected row and latch until addressed again.
// - Display rows: bits 10..6 one digit, 5..1 another, bit 11 special.
// - Any set relay in the unmanned-flight row sets status bit 15.
`include "keypad_entry_map.vh"
`default_nettype none

module keypad_entry_and_row_decoder #(
    parameter BLINK_HALF_CYCLES = `BLINK_HALF_MS * `CLK_KHZ
) (
    // Clock and reset
    input  wire          core_clk,
    input  wire          rst,
    // Keyboard
    input  wire [4:0]    key_code,
    input  wire          key_strobe,
    input  wire          key_lift_signal,
    // Switches
    input  wire          uplink_switch_accept,
    input  wire          uplink_data_present,
    // Register port
    input  wire [3:0]    reg_addr,
    input  wire [31:0]   reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output reg  [31:0]   reg_rdata_q,
    // Entry display
    output reg  [9:0]    verb_code_q,
    output reg  [9:0]    noun_code_q,
    output reg  [24:0]   data_code_q,
    output reg           data_plus_q,
    output reg           data_minus_q,
    output reg           vn_flash_on_q,
    // Lamps and alarm control
    output reg           comp_fail_lamp_q,
    output reg           key_release_lamp_q,
    output reg           activity_lamp_q,
    output reg           uplink_accept_lamp_q,
    output reg           lamp_clear_pulse_q,
    // Relay matrix
    output reg  [3:0]    row_code_bits_q,
    output reg  [12:0]   row_select_q,
    output reg  [10:0]   col_drive_q,
    output reg  [142:0]  relay_q,
    output reg           c_row_or_q
);

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_VERB = 4'b0010;
    localparam [3:0] ST_NOUN = 4'b0100;
    localparam [3:0] ST_DATA = 4'b1000;

    localparam [25:0] BLINK_LAST = BLINK_HALF_CYCLES - 1;
    localparam [51:0] ROW_TABLE  = `ROW_CODE_TABLE;

    reg  [3:0]   state_q;
    reg  [2:0]   cnt_q;

    reg          trap_q;
    reg  [4:0]   last_key_q;
    reg  [3:0]   ctl_q;
    reg  [15:0]  word_q;

    reg          exec_q;
    reg          ready_q;
    reg          flash_q;
    reg          decimal_q;
    reg          operator_q;
    reg          mix_err_q;

    reg  [25:0]  blink_cnt_q;
    reg          blink_q;

    wire         key_take;
    wire         is_digit;
    wire         word_wr;
    wire         status_rd;

    wire [7:0]   row_tc;
    wire [12:0]  row_hit;

    wire         set_exec;
    wire         set_ready;
    wire         set_fail;
    wire         clr_fail;
    wire         set_mix;

    // Only one key per press; the lift reopens the trap
    assign key_take  = key_strobe & ~trap_q;
    assign is_digit  = ((key_code != `KEY_BLANK) && (key_code <= `KEY_NINE))
                       || (key_code == `KEY_ZERO);
    assign word_wr   = reg_wr && (reg_addr == `OFS_OUT_WORD);

    assign status_rd = reg_rd && (reg_addr == `OFS_STATUS);

    // Sticky flag events
    assign set_exec  = key_take && (key_code == `KEY_ENTER) && !flash_q;
    assign set_ready = key_take && (key_code == `KEY_ENTER) && flash_q;

    assign set_fail  = (key_take && is_digit && (state_q == ST_DATA) && !decimal_q
                        && ((key_code == `KEY_EIGHT) || (key_code == `KEY_NINE)))
                       || (reg_wr && (reg_addr == `OFS_CONTROL)
                           && reg_wdata[`CTL_RAISE_ALARM]);
    assign clr_fail  = key_take && (key_code == `KEY_ERR_RESET);

    assign set_mix   = key_take && (state_q == ST_DATA) && (cnt_q != 3'd0)
                       && ((key_code == `KEY_PLUS) || (key_code == `KEY_MINUS));

    always @(posedge core_clk) begin
        if (rst) begin
            trap_q <= 1'b0;
        end else if (key_take) begin
            trap_q <= 1'b1;
        end else if (key_lift_signal) begin
            trap_q <= 1'b0;
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    always @(posedge core_clk) begin
        if (rst) begin
            exec_q           <= 1'b0;
            ready_q          <= 1'b0;
            mix_err_q        <= 1'b0;
            comp_fail_lamp_q <= 1'b0;
        end else begin
            exec_q           <= set_exec | (exec_q & ~status_rd);

            ready_q          <= set_ready | (ready_q & ~status_rd);
            mix_err_q        <= set_mix | (mix_err_q & ~status_rd);
            comp_fail_lamp_q <= set_fail | (comp_fail_lamp_q & ~clr_fail);
        end
    end

    // Keyboard entry interpreter
    always @(posedge core_clk) begin
        if (rst) begin
            state_q            <= ST_IDLE;
            cnt_q              <= 3'd0;
            last_key_q         <= `KEY_BLANK;
            verb_code_q        <= 10'h000;
            noun_code_q        <= 10'h000;
            data_code_q        <= 25'h0000000;
            data_plus_q        <= 1'b0;
            data_minus_q       <= 1'b0;
            decimal_q          <= 1'b0;
            flash_q            <= 1'b0;
            operator_q         <= 1'b0;
            lamp_clear_pulse_q <= 1'b0;
        end else begin
            lamp_clear_pulse_q <= 1'b0;
            if (key_take) begin
                last_key_q <= key_code;

                case (key_code)
                    `KEY_VERB: begin
                        verb_code_q <= 10'h000;
                        state_q     <= ST_VERB;
                        cnt_q       <= 3'd0;
                        operator_q  <= 1'b1;
                    end
                    `KEY_NOUN: begin
                        noun_code_q <= 10'h000;
                        state_q     <= ST_NOUN;
                        cnt_q       <= 3'd0;
                        operator_q  <= 1'b1;
                    end
                    `KEY_ENTER: begin
                        cnt_q <= 3'd0;
                        if (flash_q) begin
                            flash_q <= 1'b0;
                            state_q <= ST_IDLE;
                        end else if (ctl_q[`CTL_NEED_DATA]) begin
                            flash_q      <= 1'b1;
                            state_q      <= ST_DATA;
                            data_code_q  <= 25'h0000000;
                            data_plus_q  <= 1'b0;
                            data_minus_q <= 1'b0;
                            decimal_q    <= 1'b0;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                    `KEY_CLEAR: begin
                        if (state_q == ST_DATA) begin
                            data_code_q  <= 25'h0000000;
                            data_plus_q  <= 1'b0;
                            data_minus_q <= 1'b0;
                            decimal_q    <= 1'b0;
                            cnt_q        <= 3'd0;
                        end
                    end
                    `KEY_ERR_RESET: begin
                        lamp_clear_pulse_q <= 1'b1;
                    end
                    `KEY_RELEASE: begin
                        operator_q <= 1'b0;
                    end
                    `KEY_PLUS, `KEY_MINUS: begin
                        // Sign after digits would mix radices
                        if ((state_q == ST_DATA) && (cnt_q == 3'd0)) begin
                            data_plus_q  <= (key_code == `KEY_PLUS);
                            data_minus_q <= (key_code == `KEY_MINUS);
                            decimal_q    <= 1'b1;
                        end
                    end
                    default: begin
                        if (is_digit) begin
                            case (state_q)
                                ST_VERB: begin
                                    if (cnt_q == 3'd0) begin
                                        verb_code_q[9:5] <= key_code;
                                        cnt_q            <= 3'd1;
                                    end else begin
                                        verb_code_q[4:0] <= key_code;
                                        state_q          <= ST_IDLE;
                                    end
                                end
                                ST_NOUN: begin
                                    if (cnt_q == 3'd0) begin
                                        noun_code_q[9:5] <= key_code;
                                        cnt_q            <= 3'd1;
                                    end else begin
                                        noun_code_q[4:0] <= key_code;
                                        state_q          <= ST_IDLE;
                                    end
                                end
                                ST_DATA: begin
                                    // An octal 8 or 9 alarms and is not stored
                                    if ((decimal_q || ((key_code != `KEY_EIGHT)
                                         && (key_code != `KEY_NINE)))
                                        && (cnt_q != 3'd5)) begin
                                        data_code_q <= {data_code_q[19:0], key_code};
                                        cnt_q       <= cnt_q + 3'd1;
                                    end
                                end
                                default: begin
                                    cnt_q <= 3'd0;
                                end
                            endcase
                        end
                    end
                endcase
            end
        end
    end

    // Blink timebase for the verb and noun flash
    always @(posedge core_clk) begin
        if (rst) begin
            blink_cnt_q   <= 26'h0000000;
            blink_q       <= 1'b0;
            vn_flash_on_q <= 1'b0;

        end else begin
            if (!flash_q || (blink_cnt_q == BLINK_LAST)) begin
                blink_cnt_q <= 26'h0000000;
                blink_q     <= flash_q & ~blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 26'h0000001;
            end
            // Flash relay of row 11 is ORed in, but blink_q only toggles while flash_q is set
            vn_flash_on_q <= (flash_q | relay_q[10*`COLS + 10]) & blink_q;
        end
    end

    // Lamps and control register
    always @(posedge core_clk) begin
        if (rst) begin
            ctl_q                <= `CTL_RESET;
            activity_lamp_q      <= 1'b0;
            key_release_lamp_q   <= 1'b0;
            uplink_accept_lamp_q <= 1'b0;

        end else begin
            if (reg_wr && (reg_addr == `OFS_CONTROL)) begin
                ctl_q <= {1'b0, reg_wdata[2:0]};
            end
            activity_lamp_q      <= ctl_q[`CTL_RUNNING];
            key_release_lamp_q   <= ctl_q[`CTL_DISP_REQ] & operator_q;
            uplink_accept_lamp_q <= uplink_switch_accept & uplink_data_present;
        end
    end

    // Row decoder: the code in true and complemented form
    assign row_tc = {reg_wdata[`WORD_ROW_MSB:`WORD_ROW_LSB],
                     ~reg_wdata[`WORD_ROW_MSB:`WORD_ROW_LSB]};

    always @(posedge core_clk) begin
        if (rst) begin
            word_q          <= 16'h0000;
            row_code_bits_q <= 4'h0;
            col_drive_q     <= 11'h000;
            row_select_q    <= 13'h0000;
            c_row_or_q      <= 1'b0;

        end else begin
            if (word_wr) begin
                word_q <= {reg_wdata[15:1], 1'b0};
            end
            // Select lasts one cycle per word written
            row_select_q    <= word_wr ? row_hit : 13'h0000;
            row_code_bits_q <= word_q[`WORD_ROW_MSB:`WORD_ROW_LSB];
            col_drive_q     <= word_q[`WORD_COL_MSB:`WORD_COL_LSB];
            c_row_or_q      <= |relay_q[`C_ROW_INDEX*`COLS +: `COLS];
        end
    end

    // Relays load on the write itself

    genvar r;
    generate
        for (r = 0; r < `ROWS; r = r + 1) begin : g_row
            wire [3:0] rc_w = ROW_TABLE[r*4 +: 4];
            assign row_hit[r] = (row_tc == {rc_w, ~rc_w});
            always @(posedge core_clk) begin
                if (rst) begin
                    relay_q[r*`COLS +: `COLS] <= 11'h000;
                end else if (word_wr && row_hit[r]) begin
                    // Digits sit in 10..6 and 5..1, bit 11 is sign or flag
                    relay_q[r*`COLS +: `COLS] <= reg_wdata[11:1];
                end
            end
        end
    endgenerate

    // Read port: data stands in the cycle after the strobe
    always @(posedge core_clk) begin
        if (rst) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin

            case (reg_addr)
                `OFS_OUT_WORD:  reg_rdata_q <= {16'h0000, word_q};
                `OFS_STATUS:    reg_rdata_q <= {16'h0000, c_row_or_q, 2'b00, flash_q,
                                                mix_err_q, operator_q, decimal_q,
                                                key_release_lamp_q, comp_fail_lamp_q,
                                                ready_q, exec_q, last_key_q};
                `OFS_CONTROL:   reg_rdata_q <= {28'h0000000, ctl_q};
                `OFS_VERB_NOUN: reg_rdata_q <= {12'h000, noun_code_q, verb_code_q};
                `OFS_DATA:      reg_rdata_q <= {5'h00, data_minus_q, data_plus_q,
                                                data_code_q};
                default:        reg_rdata_q <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end

endmodule // keypad_entry_and_row_decoder

`default_nettype wire

/* File: rtl/keypad_entry_map.vh */
`ifndef KEYPAD_ENTRY_MAP_VH
`define KEYPAD_ENTRY_MAP_VH

// Register word offsets
`define OFS_OUT_WORD      4'h0
`define OFS_STATUS        4'h1
`define OFS_CONTROL       4'h2
`define OFS_VERB_NOUN     4'h3
`define OFS_DATA          4'h4

// Control register fields and reset value
`define CTL_RUNNING       0
`define CTL_NEED_DATA     1
`define CTL_DISP_REQ      2
`define CTL_RAISE_ALARM   3
`define CTL_RESET         4'h0

// Status register fields
`define ST_LAST_KEY_LSB   0
`define ST_EXEC           5
`define ST_DATA_READY     6
`define ST_COMP_FAIL      7
`define ST_REL_LAMP       8
`define ST_DECIMAL        9
`define ST_OPERATOR       10
`define ST_MIX_ERR        11
`define ST_FLASH          12
`define ST_C_ROW_OR       15

// Data register fields
`define DATA_PLUS         25
`define DATA_MINUS        26

// Output word fields
`define WORD_ROW_MSB      15
`define WORD_ROW_LSB      12
`define WORD_COL_MSB      11
`define WORD_COL_LSB      1

// Keycodes
`define KEY_ZERO          5'h10
`define KEY_EIGHT         5'h08
`define KEY_NINE          5'h09
`define KEY_VERB          5'h11
`define KEY_ERR_RESET     5'h12
`define KEY_RELEASE       5'h19
`define KEY_PLUS          5'h1A
`define KEY_MINUS         5'h1B
`define KEY_ENTER         5'h1C
`define KEY_CLEAR         5'h1E
`define KEY_NOUN          5'h1F
`define KEY_BLANK         5'h00

// Row codes, row 13 in the top nibble
`define ROW_CODE_TABLE    52'hEBA987C654321
`define ROWS              13
`define COLS              11
`define C_ROW_INDEX       12

// Half period of the flash blink
`define BLINK_HALF_MS     500
`define CLK_KHZ           50000

`endif

/* File: tb/keypad_entry_and_row_decoder_assertions.sv */
`include "keypad_entry_map.vh"
`default_nettype none
module keypad_entry_checker (
    // Clock and reset
    input wire logic         core_clk,
    input wire logic         rst,
    // Keys, switches, register port
    input wire logic [4:0]   key_code,
    input wire logic         key_strobe,
    input wire logic         key_lift_signal,
    input wire logic         uplink_switch_accept,
    input wire logic         uplink_data_present,
    input wire logic [3:0]   reg_addr,
    input wire logic [31:0]  reg_wdata,
    input wire logic         reg_wr,
    // Watched outputs
    input wire logic         lamp_clear_pulse_q,
    input wire logic         comp_fail_lamp_q,
    input wire logic         activity_lamp_q,
    input wire logic         uplink_accept_lamp_q,
    input wire logic         vn_flash_on_q,
    input wire logic [12:0]  row_select_q,
    input wire logic [10:0]  col_drive_q,
    input wire logic [142:0] relay_q,
    input wire logic         c_row_or_q
);
    logic trap_q;
    logic run_q;
    wire  err_take = key_strobe && trap_q && key_code == `KEY_ERR_RESET;
    wire  outw     = reg_wr && reg_addr == `OFS_OUT_WORD;
    wire  raise    = reg_wr && reg_addr == `OFS_CONTROL && reg_wdata[`CTL_RAISE_ALARM];
    wire  up_both  = uplink_switch_accept && uplink_data_present;
    wire  c_any    = |relay_q[142:132];

    // Key trap mirror, high is open
    always @(posedge core_clk) begin
        if (rst) begin
            trap_q <= 1'b1;
            run_q  <= 1'b0;
        end else begin
            if (key_strobe && trap_q) begin
                trap_q <= 1'b0;
            end else if (key_lift_signal) begin
                trap_q <= 1'b1;
            end
            if (reg_wr && reg_addr == `OFS_CONTROL) begin
                run_q <= reg_wdata[`CTL_RUNNING];
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    clear_pulse_a: assert property (!$past(rst) |-> lamp_clear_pulse_q == $past(err_take))
        else $error("clear pulse wrong");
    fail_clear_a: assert property (err_take && !raise |=> !comp_fail_lamp_q)
        else $error("fail lamp not cleared");
    activity_lamp_a: assert property (!$past(rst) |-> activity_lamp_q == $past(run_q))
        else $error("activity lamp wrong");
    uplink_lamp_a: assert property (!$past(rst) |-> uplink_accept_lamp_q == $past(up_both))
        else $error("uplink lamp wrong");
    row_one_a: assert property (outw && reg_wdata[15:12] == 4'h1 |=> row_select_q == 13'h0001)
        else $error("row one not selected");
    row_onehot_a: assert property (outw && reg_wdata[15:12] inside {[4'h1:4'hC], 4'hE}
        |=> $onehot(row_select_q)) else $error("row select not one-hot");
    row_idle_a: assert property (!$past(rst) && !$past(outw) |-> row_select_q == 13'h0000)
        else $error("stray row select");
    col_drive_a: assert property (outw |-> ##2 col_drive_q == $past(reg_wdata[11:1], 2))
        else $error("column drive wrong");
    row_latch_a: assert property (outw && reg_wdata[15:12] == 4'h1
        |=> relay_q[10:0] == $past(reg_wdata[11:1])) else $error("row one not loaded");
    c_row_or_a: assert property (!$past(rst) |-> c_row_or_q == $past(c_any))
        else $error("row 13 status wrong");

    cover property (err_take);
    cover property (outw && reg_wdata[15:12] == 4'hE);
    cover property ($rose(vn_flash_on_q));
endmodule // keypad_entry_checker

bind keypad_entry_and_row_decoder keypad_entry_checker u_chk (.*);
`default_nettype wire

/* File: tb/keypad_entry_and_row_decoder_tb_top.sv */
`include "keypad_entry_map.vh"
`default_nettype none
module keypad_entry_and_row_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic         core_clk, rst, press_req, reg_wr, reg_rd;
    logic         uplink_switch_accept, uplink_data_present;
    logic [4:0]   press_code, key_code;
    logic         key_strobe, key_lift_signal;
    logic [3:0]   reg_addr, row_code_bits_q;
    logic [31:0]  reg_wdata, reg_rdata_q;
    logic [9:0]   verb_code_q, noun_code_q;
    logic [24:0]  data_code_q;
    logic         data_plus_q, data_minus_q, vn_flash_on_q, comp_fail_lamp_q;
    logic         key_release_lamp_q, activity_lamp_q, uplink_accept_lamp_q;
    logic         lamp_clear_pulse_q, c_row_or_q;
    logic [12:0]  row_select_q;
    logic [10:0]  col_drive_q;
    logic [142:0] relay_q;
    int           err_total = 0;
    int           checked = 0;

    keypad_operator_model op (.*);
    keypad_entry_and_row_decoder #(.BLINK_HALF_CYCLES(4)) DUT (.*);

    task automatic finish_test();
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_relays(input logic [142:0] exp);
        checked++;
        if (relay_q !== exp) begin
            err_total++;
            $display("wrong value relays expected %h seen %h", exp, relay_q);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask
    task automatic press(input logic [4:0] k);
        @(posedge core_clk);
        press_req  <= 1'b1;
        press_code <= k;
        @(posedge core_clk);
        press_req <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask
    function automatic logic [4:0] dk(input int n);
        return (n == 0) ? 5'h10 : 5'(n);
    endfunction
    function automatic int row_of(input logic [3:0] c);
        row_of = 13;
        for (int k = 0; k < `ROWS; k++) begin
            if (4'(`ROW_CODE_TABLE >> (4 * k)) == c) row_of = k;
        end
    endfunction
    task automatic field(input logic [4:0] key, output logic [9:0] e);
        logic [4:0] a;
        logic [4:0] b;
        a = dk($urandom % 10);
        b = dk($urandom % 10);
        press(key);
        chk("field blank", 10'h000, key == `KEY_VERB ? verb_code_q : noun_code_q);
        press(a);
        press(b);
        e = {a, b};
        chk("field code", e, key == `KEY_VERB ? verb_code_q : noun_code_q);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (8000) @(posedge core_clk);
        err_total++;
        finish_test();
    end
    initial begin
        logic [31:0]  v;
        logic [9:0]   ve, ne;
        logic [10:0]  cols;
        logic [3:0]   code;
        logic [142:0] rexp;
        int           r;
        rst = 1'b1;
        {press_req, press_code, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {uplink_switch_accept, uplink_data_present} = '0;
        rexp = '0;
        v = $urandom(32'hC944B06A);
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        wr(`OFS_CONTROL, 32'h0000_0001);
        settle();
        chk("activity", 1, activity_lamp_q);
        field(`KEY_VERB, ve);
        field(`KEY_NOUN, ne);
        field(`KEY_VERB, ve);
        chk("noun kept", ne, noun_code_q);
        rd(`OFS_STATUS, v);
        chk("exec early", 0, v[`ST_EXEC]);
        press(`KEY_ENTER);
        rd(`OFS_STATUS, v);
        chk("exec", 1, v[`ST_EXEC]);
        wr(`OFS_CONTROL, 32'h0000_0003);
        field(`KEY_VERB, ve);
        field(`KEY_NOUN, ne);
        press(`KEY_ENTER);
        r = 0;
        while (vn_flash_on_q !== 1'b1 && r < 40) begin
            settle();
            r++;
        end
        chk("flash on", 1, vn_flash_on_q);
        for (int s = 0; s < 2; s++) begin
            press(s == 0 ? `KEY_PLUS : `KEY_MINUS);
            rd(`OFS_STATUS, v);
            chk("decimal", 1, v[`ST_DECIMAL]);
            chk("sign", s == 0 ? 2'b10 : 2'b01, {data_plus_q, data_minus_q});
            press(dk(9));
            chk("no fail", 0, comp_fail_lamp_q);
            chk("dec data", 25'h09, data_code_q);
            press(`KEY_CLEAR);
            chk("cleared", 27'h0, {data_plus_q, data_minus_q, data_code_q});
        end
        press(dk(8));
        chk("octal alarm", 1, comp_fail_lamp_q);
        press(dk(1));
        press(dk(2));
        chk("oct data", 25'h22, data_code_q);
        press(`KEY_PLUS);
        rd(`OFS_STATUS, v);
        chk("mix refused", 2'b10, {v[`ST_MIX_ERR], data_plus_q});
        press(`KEY_ENTER);
        rd(`OFS_STATUS, v);
        chk("data ready", 2'b10, {v[`ST_DATA_READY], v[`ST_FLASH]});
        repeat (12) settle();
        chk("flash off", 0, vn_flash_on_q);
        press(`KEY_ERR_RESET);
        chk("fail off", 0, comp_fail_lamp_q);
        wr(`OFS_CONTROL, 32'h0000_0009);
        settle();
        chk("raised", 1, comp_fail_lamp_q);
        press(`KEY_ERR_RESET);
        chk("fail off", 0, comp_fail_lamp_q);
        field(`KEY_VERB, ve);
        wr(`OFS_CONTROL, 32'h0000_0005);
        settle();
        chk("release lamp", 1, key_release_lamp_q);
        press(`KEY_RELEASE);
        settle();
        chk("release off", 0, key_release_lamp_q);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            uplink_switch_accept <= i[0];
            uplink_data_present  <= i[1];
            repeat (2) settle();
            chk("uplink", i == 3, uplink_accept_lamp_q);
        end
        for (int i = 0; i < 20; i++) begin
            code = i < 16 ? i[3:0] : 4'hE;
            cols = i == 19 ? 11'h000 : 11'($urandom);
            wr(`OFS_OUT_WORD, {16'h0000, code, cols, 1'b0});
            r = row_of(code);
            if (r < 13) rexp[r * 11 +: 11] = cols;
            #1;
            chk_relays(rexp);
            settle();
            chk("cols", cols, col_drive_q);
            chk("row bits", code, row_code_bits_q);
            chk("c row", |rexp[142:132], c_row_or_q);
            rd(`OFS_OUT_WORD, v);
            chk("word", {16'h0000, code, cols, 1'b0}, v);
        end
        for (int i = 1; i < 32; i++) begin
            if (!(i inside {[1:9], [16:18], [25:28], 30, 31})) continue;
            press(5'(i));
            rd(`OFS_STATUS, v);
            chk("keycode", i, v[4:0]);
        end
        finish_test();
    end
endmodule // keypad_entry_and_row_decoder_tb_top
`default_nettype wire

/* File: tb/keypad_operator_model.sv */
`default_nettype none
module keypad_operator_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Press request from the bench
    input  wire logic       press_req,
    input  wire logic [4:0] press_code,
    // Key contacts
    output var  logic [4:0] key_code,
    output var  logic       key_strobe,
    output var  logic       key_lift_signal
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge core_clk) begin
        if (rst) begin
            key_code        <= 5'h00;
            key_strobe      <= 1'b0;
            key_lift_signal <= 1'b0;
        end else begin
            key_strobe      <= press_req;
            key_lift_signal <= key_strobe;
            if (press_req) begin
                key_code <= press_code;
            end else begin
                key_code <= ~key_code; // Open contacts
            end
        end
    end
endmodule // keypad_operator_model
`default_nettype wire
